/* design/umf_map.svh */
/*
 * register offsets, field positions, reset values and lookup constants
 * for the uart modem status and feature control block.
 * assumes a classic wishbone slave with 32-bit data, byte addresses.
 */
// Contract
// R1: cd, dsr, cts change flags set on change
// R2: ring change flag set on low-to-high only
// R3: any change flag plus enable raises interrupt
// R4: status read clears all four change flags
// R5: status address writes go to control register
// R6: turn-around delay 0..15 bit times
// R7: control bits change only while enhanced enabled
// R8: transmitter disable halts shifter, bytes stay queued
// R9: send immediate blocked while transmitter disabled
// R10: receiver disable finishes current char, then stops
// R11: re-enable receiver only while line idle
// R12: receive fifo readable whether receiver disabled
// R13: scratch pad read/write, resets to 0xff
// R14: tables a-c use next trigger levels
// R15: rs485 off: interrupt on holding empty
// R16: rs485 direction high on load, low after stop
// R17: rs485 on: interrupt on shifter empty
// R18: feature bit 4 selects irda rx polarity
// R19: hysteresis bits only valid with table d
// R20: flow stops at trig+hyst, resumes trig-hyst
// R21: codes 0-7 give 0,4,6,8,8,16,24,32
// R22: codes 8-15 give 40..52 then 12..36
// R23: upper status bits are inverted modem pins
// R24: enhanced bits latched while enhanced disabled
`ifndef UMF_MAP_SVH
`define UMF_MAP_SVH

`define UMF_ADR_STATUS 4'h0
`define UMF_ADR_SCRATCH 4'h4
`define UMF_ADR_FEATURE 4'h8
`define UMF_ADR_ENHANCE 4'hc

`define UMF_SCRATCH_RST 8'hff
`define UMF_FEATURE_RST 8'h00

`define UMF_FC_TABLE_HI 7
`define UMF_FC_TABLE_LO 6
`define UMF_FC_RS485 5
`define UMF_FC_IRDA_INV 4
`define UMF_TABLE_D 2'h3

`define UMF_CT_DELAY_HI 7
`define UMF_CT_DELAY_LO 4
`define UMF_CT_TX_DIS 3
`define UMF_CT_RX_DIS 2

`define UMF_EN_MSI 0
`define UMF_EN_ENH 1

`endif

/* design/umf_pkg.sv */
/*
 * types shared by the modem status and feature control block.
 * assumes nothing beyond a systemverilog compiler.
 */
package umf_pkg;

	typedef struct packed {
		logic cd;
		logic ri;
		logic dsr;
		logic cts;
	} umf_modem_t;

	typedef enum logic [1:0] {
		UMF_DIR_IDLE,
		UMF_DIR_SEND,
		UMF_DIR_HOLD
	} umf_dir_state_t;

endpackage

/* design/umf_ctrl.sv */
/*
 * per-channel modem status flags, turn-around and disable control,
 * scratch pad, feature control, rs485 direction and flow hysteresis.
 * assumes the transmitter, receiver, fifos and baud generator sit
 * outside on the same clock; modem and irda pins are asynchronous.
 */
`include "umf_map.svh"

module umf_ctrl (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// modem pins, active low, asynchronous
	input wire umf_pkg::umf_modem_t modem_n_i,
	output logic modem_irq_o,
	// transmitter side
	input wire logic bit_tick_i,
	input wire logic tsr_load_i,
	input wire logic thr_empty_i,
	input wire logic tsr_empty_i,
	input wire logic send_imm_req_i,
	output logic tx_halt_o,
	output logic send_imm_go_o,
	output logic tx_irq_o,
	output logic rs485_dir_o,
	// receiver side
	input wire logic rx_busy_i,
	input wire logic rx_pop_i,
	input wire logic irda_rx_i,
	output logic rx_start_ok_o,
	output logic rx_pop_o,
	output logic irda_rx_o,
	// flow control
	input wire logic [7:0] rx_level_i,
	input wire logic [7:0] rx_trig_i,
	input wire logic [7:0] next_up_i,
	input wire logic [7:0] next_dn_i,
	output logic flow_stop_o
);

	// hysteresis in characters for each code
	function automatic logic [7:0] hyst_chars(input logic [3:0] code);
		case (code) // R21 R22
			4'h0: hyst_chars = 8'h00;
			4'h1: hyst_chars = 8'h04;
			4'h2: hyst_chars = 8'h06;
			4'h3: hyst_chars = 8'h08;
			4'h4: hyst_chars = 8'h08;
			4'h5: hyst_chars = 8'h10;
			4'h6: hyst_chars = 8'h18;
			4'h7: hyst_chars = 8'h20;
			4'h8: hyst_chars = 8'h28;
			4'h9: hyst_chars = 8'h2c;
			4'ha: hyst_chars = 8'h30;
			4'hb: hyst_chars = 8'h34;
			4'hc: hyst_chars = 8'h0c;
			4'hd: hyst_chars = 8'h14;
			4'he: hyst_chars = 8'h1c;
			default: hyst_chars = 8'h24;
		endcase
	endfunction

	// address match shared by every register select
	function automatic logic adr_is(input logic [3:0] a,
		input logic [3:0] off);
		adr_is = a == off;
	endfunction

	// registers
	logic [7:0] scratch;
	logic [7:0] feature;
	logic [7:0] turn_ctrl;
	logic msi_en;
	logic enh_en;
	logic [3:0] delta;
	logic ack;
	logic [31:0] rdata;

	// modem and irda pin synchronisers
	umf_pkg::umf_modem_t modem_meta;
	umf_pkg::umf_modem_t modem_sync;
	umf_pkg::umf_modem_t modem_prev;
	logic irda_meta;
	logic irda_sync;

	// rs485 direction, receive gating and flow state
	umf_pkg::umf_dir_state_t dir_state;
	umf_pkg::umf_dir_state_t next_dir_state;
	logic [3:0] hold_cnt;
	logic [3:0] next_hold_cnt;
	logic rx_dis_eff;
	logic flow_stop;

	// bus decode
	wire req = wb_cyc_i & wb_stb_i & ~ack;
	// a write needs the low byte lane; reads ignore the lanes
	wire wr = req & wb_we_i & wb_sel_i[0];
	wire rd = req & ~wb_we_i;
	wire hit_status = adr_is(wb_adr_i, `UMF_ADR_STATUS);
	wire hit_scratch = adr_is(wb_adr_i, `UMF_ADR_SCRATCH);
	wire hit_feature = adr_is(wb_adr_i, `UMF_ADR_FEATURE);
	wire hit_enhance = adr_is(wb_adr_i, `UMF_ADR_ENHANCE);
	wire [7:0] wbyte = wb_dat_i[7:0];
	wire status_rd = rd & hit_status;

	// modem status view: inverted pins above change flags
	wire [7:0] status_val = {~modem_sync.cd, ~modem_sync.ri, // R23
		~modem_sync.dsr, ~modem_sync.cts, delta};
	wire [7:0] enh_val = {6'h00, enh_en, msi_en};
	wire [7:0] rd_mux = hit_status ? status_val : // R5
		hit_scratch ? scratch :
		hit_feature ? feature :
		hit_enhance ? enh_val : 8'h00;

	// change detection on synchronised pins, one slice per pin;
	// the ring pin only flags its low to high end of ringing
	logic [3:0] pin_now;
	logic [3:0] pin_was;
	logic [3:0] delta_set;
	assign pin_now = modem_sync;
	assign pin_was = modem_prev;
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_chg
			if (gi == 2) begin : g_ring
				assign delta_set[gi] = pin_now[gi] & ~pin_was[gi]; // R2
			end else begin : g_level
				assign delta_set[gi] = pin_now[gi] ^ pin_was[gi]; // R1
			end
		end
	endgenerate
	// a change in the clearing cycle survives the read
	wire [3:0] next_delta = delta_set |
		(status_rd ? 4'h0 : delta); // R4

	// turn-around and disable bits locked unless enhanced enabled
	wire ctrl_wr = wr & hit_status & enh_en; // R5 R7 R24
	wire [7:0] next_turn_ctrl = ctrl_wr ?
		{wbyte[7:2], 2'b00} : turn_ctrl;

	wire tx_dis = turn_ctrl[`UMF_CT_TX_DIS];
	wire rx_dis = turn_ctrl[`UMF_CT_RX_DIS];
	wire [3:0] turn_delay = turn_ctrl[`UMF_CT_DELAY_HI:`UMF_CT_DELAY_LO];
	wire rs485_on = feature[`UMF_FC_RS485];
	wire [1:0] table_sel = feature[`UMF_FC_TABLE_HI:`UMF_FC_TABLE_LO];

	// rs485 direction sequencing
	wire tx_drained = thr_empty_i & tsr_empty_i;
	always_comb begin
		next_dir_state = dir_state;
		next_hold_cnt = hold_cnt;
		unique case (dir_state)
			umf_pkg::UMF_DIR_IDLE: begin
				if (tsr_load_i) begin
					next_dir_state = umf_pkg::UMF_DIR_SEND; // R16
				end
			end
			umf_pkg::UMF_DIR_SEND: begin
				if (tx_drained & ~tsr_load_i) begin
					next_hold_cnt = turn_delay; // R6
					next_dir_state = (turn_delay == 4'h0) ?
						umf_pkg::UMF_DIR_IDLE : umf_pkg::UMF_DIR_HOLD;
				end
			end
			umf_pkg::UMF_DIR_HOLD: begin
				if (tsr_load_i) begin
					next_dir_state = umf_pkg::UMF_DIR_SEND; // R16
				end else if (bit_tick_i) begin
					next_hold_cnt = hold_cnt - 4'h1; // R6
					if (hold_cnt == 4'h1) begin
						next_dir_state = umf_pkg::UMF_DIR_IDLE;
					end
				end
			end
			default: begin
				next_dir_state = umf_pkg::UMF_DIR_IDLE;
			end
		endcase
		// direction logic is parked while the feature is off
		if (!rs485_on) begin
			next_dir_state = umf_pkg::UMF_DIR_IDLE;
		end
	end

	// transmit interrupt source follows the rs485 mode
	wire tx_irq = rs485_on ? tx_drained : thr_empty_i; // R15 R17

	// receiver gating: a char already running is allowed to finish
	// because the gate only follows the disable bit while rx_busy_i is low
	wire next_rx_dis_eff = rx_busy_i ? rx_dis_eff : rx_dis; // R10 R11

	// flow hysteresis
	// sums saturate so a large hysteresis cannot wrap past the ends
	wire table_d = table_sel == `UMF_TABLE_D;
	wire [3:0] hyst_code = feature[3:0];
	wire use_hyst = table_d & (hyst_code != 4'h0); // R19
	wire [7:0] hyst = hyst_chars(hyst_code);
	wire [8:0] up_sum = {1'b0, rx_trig_i} + {1'b0, hyst};
	wire [7:0] up_hyst = up_sum[8] ? 8'hff : up_sum[7:0];
	wire [7:0] dn_hyst = (rx_trig_i > hyst) ? rx_trig_i - hyst : 8'h00;
	wire [7:0] stop_lvl = use_hyst ? up_hyst : next_up_i; // R14 R20
	wire [7:0] go_lvl = use_hyst ? dn_hyst : next_dn_i; // R14 R20
	wire next_flow_stop = (rx_level_i >= stop_lvl) ? 1'b1 :
		(rx_level_i <= go_lvl) ? 1'b0 : flow_stop; // R20

	// pin synchronisers
	// no reset: the pins are sampled from the first clock on
	always_ff @(posedge clk_i) begin
		modem_meta <= modem_n_i;
		modem_sync <= modem_meta;
		irda_meta <= irda_rx_i;
		irda_sync <= irda_meta;
	end

	// one ack per request; read data holds until the next read
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack <= 1'b0;
			rdata <= 32'h0000_0000;
		end else begin
			ack <= req; // R5
			if (rd) begin
				rdata <= {24'h00_0000, rd_mux};
			end
		end
	end

	// bus registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			scratch <= `UMF_SCRATCH_RST; // R13
			feature <= `UMF_FEATURE_RST;
			msi_en <= 1'b0;
			enh_en <= 1'b0;
		end else begin
			if (wr & hit_scratch) begin
				scratch <= wbyte; // R13
			end
			if (wr & hit_feature) begin
				feature <= wbyte; // R14 R18 R19
			end
			if (wr & hit_enhance) begin
				msi_en <= wbyte[`UMF_EN_MSI];
				enh_en <= wbyte[`UMF_EN_ENH]; // R24
			end
		end
	end

	// modem flags and control
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			// start from the present pin level so reset flags no change
			modem_prev <= modem_sync; // R1
			delta <= 4'h0;
			turn_ctrl <= 8'h00; // R8 R10 R24
		end else begin
			modem_prev <= modem_sync;
			delta <= next_delta;
			turn_ctrl <= next_turn_ctrl;
		end
	end

	// direction state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dir_state <= umf_pkg::UMF_DIR_IDLE;
			hold_cnt <= 4'h0;
		end else begin
			dir_state <= next_dir_state;
			hold_cnt <= next_hold_cnt; // R6
		end
	end

	// receive gating state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_dis_eff <= 1'b0;
		end else begin
			rx_dis_eff <= next_rx_dis_eff; // R10
		end
	end

	// flow state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flow_stop <= 1'b0;
		end else begin
			flow_stop <= next_flow_stop;
		end
	end

	// registered modem and transmit outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			modem_irq_o <= 1'b0;
			tx_halt_o <= 1'b0;
			send_imm_go_o <= 1'b0;
			tx_irq_o <= 1'b0;
			rs485_dir_o <= 1'b0;
		end else begin
			modem_irq_o <= msi_en & (|next_delta); // R3 R4
			tx_halt_o <= tx_dis; // R8
			send_imm_go_o <= send_imm_req_i & ~tx_dis; // R9
			tx_irq_o <= tx_irq; // R15 R17
			rs485_dir_o <= next_dir_state != umf_pkg::UMF_DIR_IDLE; // R16
		end
	end

	// registered receive outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_start_ok_o <= 1'b0;
			rx_pop_o <= 1'b0;
			irda_rx_o <= 1'b0;
		end else begin
			rx_start_ok_o <= ~next_rx_dis_eff; // R10
			// fifo pops are never gated by the receiver disable
			rx_pop_o <= rx_pop_i; // R12
			irda_rx_o <= irda_sync ^ feature[`UMF_FC_IRDA_INV]; // R18
		end
	end

	// registered flow output
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flow_stop_o <= 1'b0;
		end else begin
			flow_stop_o <= next_flow_stop; // R20
		end
	end

	assign wb_ack_o = ack;
	assign wb_dat_o = rdata;

endmodule // umf_ctrl

/* sim/umf_ctrl_assertions.sv */
/* port assertions for umf_ctrl
   assumes a bind from the bench top */
module umf_ctrl_assertions (
	// clock and bus
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	// transmit and receive
	input wire logic tsr_load_i,
	input wire logic thr_empty_i,
	input wire logic tsr_empty_i,
	input wire logic send_imm_req_i,
	input wire logic tx_halt_o,
	input wire logic send_imm_go_o,
	input wire logic rs485_dir_o,
	input wire logic rx_busy_i,
	input wire logic rx_start_ok_o,
	input wire logic rx_pop_i,
	input wire logic rx_pop_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
		wb_ack_o) else $error("ack late");
	AST_ONE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	AST_HI: assert property (wb_dat_o[31:8] == 24'h0)
		else $error("upper data set");
	AST_POP: assert property (1'b1 |=> rx_pop_o == $past(rx_pop_i))
		else $error("pop gated");
	AST_IMM: assert property (send_imm_go_o |-> $past(send_imm_req_i) &&
		!(tx_halt_o && $past(tx_halt_o))) else $error("send while halted");
	AST_DUP: assert property ($rose(rs485_dir_o) |-> $past(tsr_load_i))
		else $error("dir up without load");
	AST_DDN: assert property ($fell(rs485_dir_o) |->
		$past(thr_empty_i && tsr_empty_i)) else $error("dir down early");
	AST_RXD: assert property ($fell(rx_start_ok_o) |-> !$past(rx_busy_i))
		else $error("char cut");
	AST_RST: assert property ($past(rst_i) |->
		!tx_halt_o && !rs485_dir_o && !wb_ack_o) else $error("reset value");
endmodule // umf_ctrl_assertions

/* sim/umf_line_model.sv */
/* transmitter far side: queue count, shifter, bit ticks
   assumes the clock of the control block */
module umf_line_model (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// halt from block, push from bench
	input wire logic halt_i,
	input wire logic push_i,
	// to block
	output logic tick_o,
	output logic load_o,
	output logic thr_empty_o,
	output logic tsr_empty_o
);
	logic [3:0] qd;
	logic [5:0] bits;
	logic [1:0] div;
	logic go;
	assign thr_empty_o = qd == 4'h0;
	assign tsr_empty_o = bits == 6'h0;
	// a halted shifter leaves queued bytes unsent
	assign go = !halt_i && !thr_empty_o && tsr_empty_o;
	always_ff @(posedge clk_i) begin
		div <= rst_i ? 2'h0 : div + 2'h1;
		tick_o <= !rst_i && div == 2'h3;
		load_o <= !rst_i && go;
		qd <= rst_i ? 4'h0 : qd - {3'h0, go} + {3'h0, push_i};
		if (rst_i) bits <= 6'h0;
		else if (go) bits <= 6'ha;
		else if (tick_o && bits != 6'h0) bits <= bits - 6'h1;
	end
endmodule // umf_line_model

/* sim/umf_ctrl_tb.sv */
/* self-checking bench for umf_ctrl, random stimulus
   assumes the line model as transmitter far side */
module umf_ctrl_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0;
	logic push = 1'b0, busy = 1'b0;
	logic [3:0] sel = 4'hf, adr = 4'h0;
	logic [7:0] wd = 8'h0, lvl = 8'h0;
	logic [2:0] rq = 3'h0;
	logic [15:0] rs = 16'h10;
	umf_pkg::umf_modem_t pins = 4'hf;
	logic [31:0] rdat;
	logic ack, mirq, halt, imm, tirq, dir, rxok, stop, tick, load, the, tse;
	logic irx;
	logic [2:0] ih = 3'h0;
	int fails = 0;
	int checked = 0;
	umf_ctrl umf_ctrl_i (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i({24'h0, wd}),
		.wb_dat_o(rdat), .wb_ack_o(ack), .modem_n_i(pins), .modem_irq_o(mirq),
		.bit_tick_i(tick), .tsr_load_i(load), .thr_empty_i(the),
		.tsr_empty_i(tse), .send_imm_req_i(rq[0]), .tx_halt_o(halt),
		.send_imm_go_o(imm), .tx_irq_o(tirq), .rs485_dir_o(dir),
		.rx_busy_i(busy), .rx_pop_i(rq[1]), .irda_rx_i(rq[2]),
		.rx_start_ok_o(rxok), .rx_pop_o(), .irda_rx_o(irx), .rx_level_i(lvl),
		.rx_trig_i(8'h64), .next_up_i(8'h6e), .next_dn_i(8'h5a),
		.flow_stop_o(stop));
	umf_line_model umf_line_model_i (.clk_i, .rst_i, .halt_i(halt),
		.push_i(push), .tick_o(tick), .load_o(load), .thr_empty_o(the),
		.tsr_empty_o(tse));
	always #12.5 clk_i = ~clk_i;
	function automatic logic [15:0] rnd();
		rs = rs ^ (rs << 7);
		rs = rs ^ (rs >> 9);
		rs = rs ^ (rs << 8);
		return rs;
	endfunction
	// ring flag only on release, the others on any change
	function automatic logic [7:0] stat(input logic [3:0] o, n);
		logic [3:0] f;
		f = (o ^ n) & 4'hb;
		f[2] = !o[2] && n[2];
		return {~n, f};
	endfunction
	function automatic logic [7:0] hy(input int c);
		logic [7:0] t[16] = '{8'h0, 8'h4, 8'h6, 8'h8, 8'h8, 8'h10, 8'h18,
			8'h20, 8'h28, 8'h2c, 8'h30, 8'h34, 8'hc, 8'h14, 8'h1c, 8'h24};
		return t[c];
	endfunction
	always @(posedge clk_i) rq <= 3'(rnd());
	// irda input history: two sync stages plus the output flop
	always @(posedge clk_i) ih <= {ih[1:0], rq[2]};
	task automatic chk(input logic [7:0] got, exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wd <= d;
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		cyc <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		wb(1'b0, a, 8'h0);
		chk(rdat[7:0], e);
	endtask
	task automatic lv(input logic [7:0] v, input logic e);
		lvl <= v;
		repeat (3) @(posedge clk_i);
		chk(8'(stop), 8'(e));
	endtask
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		#100us;
		fails++;
		give_verdict();
	end
	initial begin
		logic [7:0] e;
		logic [3:0] o;
		int c;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(4'h4, 8'hff);
		rd(4'h8, 8'h00);
		rd(4'h2, 8'h00);
		e = 8'(rnd());
		wb(1'b1, 4'h4, e);
		rd(4'h4, e);
		wb(1'b0, 4'h0, 8'h0);
		wb(1'b1, 4'hc, 8'h03);
		o = 4'hf;
		for (c = 0; c < 8; c++) begin
			pins <= 4'(rnd());
			repeat (5) @(posedge clk_i);
			e = stat(o, pins);
			o = pins;
			chk(8'(mirq), 8'(|e[3:0]));
			rd(4'h0, e);
			rd(4'h0, {e[7:4], 4'h0});
		end
		wb(1'b1, 4'hc, 8'h01);
		wb(1'b1, 4'h0, 8'h0c);
		chk(8'(halt), 8'h0);
		wb(1'b1, 4'hc, 8'h03);
		busy <= 1'b1;
		wb(1'b1, 4'h0, 8'h2c);
		repeat (20) @(posedge clk_i);
		chk(8'({halt, imm, rxok}), 8'h5);
		busy <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk(8'(rxok), 8'h0);
		wb(1'b1, 4'hc, 8'h01);
		wb(1'b1, 4'h0, 8'h00);
		chk(8'(halt), 8'h1);
		wb(1'b1, 4'hc, 8'h03);
		wb(1'b1, 4'h8, 8'h20);
		push <= 1'b1;
		@(posedge clk_i);
		push <= 1'b0;
		repeat (4) @(posedge clk_i);
		chk(8'(dir), 8'h0);
		wb(1'b1, 4'h0, 8'h20);
		for (c = 0; c < 9 && !dir; c++) @(posedge clk_i);
		chk(8'({dir, tirq, rxok}), 8'h5);
		for (c = 0; c < 99 && !tse; c++) @(posedge clk_i);
		for (c = 0; c < 20 && dir; c++) @(posedge clk_i);
		chk(8'(c > 3 && c < 12), 8'h1);
		wb(1'b1, 4'h8, 8'h00);
		push <= 1'b1;
		@(posedge clk_i);
		push <= 1'b0;
		for (c = 0; c < 9 && tse; c++) @(posedge clk_i);
		repeat (2) @(posedge clk_i);
		chk(8'({tse, tirq}), 8'h1);
		for (c = 1; c < 16; c++) begin
			wb(1'b1, 4'h8, 8'hc0 | 8'(c));
			lv(8'h63 + hy(c), 1'b0);
			lv(8'h64 + hy(c), 1'b1);
			lv(8'h65 - hy(c), 1'b1);
			lv(8'h64 - hy(c), 1'b0);
		end
		wb(1'b1, 4'h8, 8'h45);
		rd(4'h8, 8'h45);
		chk(8'(irx), 8'(ih[2]));
		lv(8'h6d, 1'b0);
		lv(8'h6e, 1'b1);
		lv(8'h5b, 1'b1);
		lv(8'h5a, 1'b0);
		wb(1'b1, 4'h8, 8'h10);
		@(posedge clk_i);
		chk(8'(irx), 8'(!ih[2]));
		give_verdict();
	end
endmodule // umf_ctrl_tb
bind umf_ctrl umf_ctrl_assertions umf_ctrl_assertions_i (.clk_i, .rst_i,
	.wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_dat_o, .tsr_load_i, .thr_empty_i,
	.tsr_empty_i, .send_imm_req_i, .tx_halt_o, .send_imm_go_o, .rs485_dir_o,
	.rx_busy_i, .rx_start_ok_o, .rx_pop_i, .rx_pop_o);
